// ==== src/fault_status_pkg.sv ====
package fault_status_pkg;

    // Register offsets on the control port
    localparam logic [7:0] ADDR_LATCHED_HEADSET = 8'h3A;
    localparam logic [7:0] ADDR_LATCHED_THRESHOLD_VOICE = 8'h3B;
    localparam logic [7:0] ADDR_LIVE_CLOCK = 8'h3C;
    localparam logic [7:0] ADDR_LIVE_CHANNEL_SUMMARY = 8'h3D;
    localparam logic [7:0] ADDR_LIVE_OUTPUT_ONE = 8'h40;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Headset register fields
    localparam int BIT_HEADSET_INSERT = 3;
    localparam int BIT_HEADSET_REMOVE = 2;
    localparam int BIT_HEADSET_HOOK = 1;

    // Threshold and voice register fields
    localparam int BIT_GPA_UPPER = 7;
    localparam int BIT_GPA_LOWER = 6;
    localparam int BIT_VOICE_POWER_UP = 5;
    localparam int BIT_VOICE_POWER_DOWN = 4;

    // Live clock register fields
    localparam int BIT_CLOCK_ERROR = 7;
    localparam int BIT_PLL_LOCK = 6;

    // Channel summary fields
    localparam int BIT_INPUT_CH1 = 7;
    localparam int BIT_INPUT_CH2 = 6;
    localparam int BIT_OUTPUT_CH1 = 5;
    localparam int BIT_OUTPUT_CH2 = 4;

    // Output one fault fields
    localparam int BIT_POS_SHORT = 7;
    localparam int BIT_NEG_SHORT = 6;
    localparam int BIT_POS_VGND = 5;
    localparam int BIT_NEG_VGND = 4;

    localparam int HEADSET_FLAGS = 3;
    localparam int THRESHOLD_VOICE_FLAGS = 4;
    localparam logic [2:0] HEADSET_FLAGS_RESET = 3'h0;
    localparam logic [3:0] THRESHOLD_VOICE_FLAGS_RESET = 4'h0;

endpackage : fault_status_pkg

// ==== src/interrupt_fault_status_readback.sv ====
// Operation
// - Headset insert sets latched bit 3 at 0x3A
// - Headset removal sets latched bit 2
// - Hook button press sets latched bit 1
// - Analog input upper threshold sets 0x3B bit 7
// - Analog input lower threshold sets bit 6
// - Voice power-up event sets bit 5
// - Voice power-down event sets bit 4
// - Clock error shows live at 0x3C bit 7
// - PLL lock shows live at bit 6
// - Input channel faults show at 0x3D bits 7,6
// - Output channel faults show at bits 5,4
// - Positive output short shows at 0x40 bit 7
// - Negative output short shows at bit 6
// - Positive driver virtual ground fault at bit 5
// - Negative driver virtual ground fault at bit 4
// - Reserved bits read zero; host writes zero
// - All status registers read 0x00 after reset
`timescale 1ns/1ps
`default_nettype none

module interrupt_fault_status_readback
    import fault_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    // Control port access
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    output logic reg_wr_ack,
    // Event inputs, high while the detector reports the event
    input wire logic headset_insert_event,
    input wire logic headset_remove_event,
    input wire logic headset_hook_event,
    input wire logic analog_input_upper_event,
    input wire logic analog_input_lower_event,
    input wire logic voice_power_up_event,
    input wire logic voice_power_down_event,
    // Live conditions
    input wire logic clock_error,
    input wire logic pll_lock,
    input wire logic input_ch1_fault,
    input wire logic input_ch2_fault,
    input wire logic output_ch1_fault,
    input wire logic output_ch2_fault,
    input wire logic output_one_positive_pin_short,
    input wire logic output_one_negative_pin_short,
    input wire logic positive_driver_vgnd_fault,
    input wire logic negative_driver_vgnd_fault
);

    logic [HEADSET_FLAGS-1:0] latched_headset_flags;
    logic [THRESHOLD_VOICE_FLAGS-1:0] latched_threshold_voice_flags;
    logic [1:0] live_clock_flags;
    logic [3:0] channel_fault_summary_bits;
    logic [3:0] output_one_fault_bits;

    logic [HEADSET_FLAGS-1:0] headset_events;
    logic [THRESHOLD_VOICE_FLAGS-1:0] threshold_voice_events;
    logic read_headset;
    logic read_threshold_voice;
    logic [7:0] headset_image;
    logic [7:0] threshold_voice_image;
    logic [7:0] live_clock_image;
    logic [7:0] channel_summary_image;
    logic [7:0] output_one_image;
    logic [7:0] next_rdata;

    // Headset flag vectors are ordered insert, remove, hook from the top
    assign headset_events = {headset_insert_event, headset_remove_event, headset_hook_event};
    assign threshold_voice_events = {analog_input_upper_event, analog_input_lower_event,
                                     voice_power_up_event, voice_power_down_event};

    // Only a read clears; write strobes do not reach the flags
    assign read_headset = reg_rd && (reg_addr == ADDR_LATCHED_HEADSET);
    assign read_threshold_voice = reg_rd && (reg_addr == ADDR_LATCHED_THRESHOLD_VOICE);

    // An event in the clearing cycle survives for the next read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latched_headset_flags <= HEADSET_FLAGS_RESET;
        end else begin
            latched_headset_flags <= (read_headset ? HEADSET_FLAGS_RESET : latched_headset_flags)
                                     | headset_events;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latched_threshold_voice_flags <= THRESHOLD_VOICE_FLAGS_RESET;
        end else begin
            latched_threshold_voice_flags <= (read_threshold_voice ? THRESHOLD_VOICE_FLAGS_RESET
                                              : latched_threshold_voice_flags)
                                             | threshold_voice_events;
        end
    end

    // Live conditions are sampled every cycle, with no latching
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            live_clock_flags <= '0;
            channel_fault_summary_bits <= '0;
            output_one_fault_bits <= '0;
        end else begin
            live_clock_flags <= {clock_error, pll_lock};
            channel_fault_summary_bits <= {input_ch1_fault, input_ch2_fault,
                                           output_ch1_fault, output_ch2_fault};
            output_one_fault_bits <= {output_one_positive_pin_short, output_one_negative_pin_short,
                                      positive_driver_vgnd_fault, negative_driver_vgnd_fault};
        end
    end

    // Register images; every bit not placed reads zero
    always_comb begin
        headset_image = STATUS_RESET;
        headset_image[BIT_HEADSET_INSERT] = latched_headset_flags[2];
        headset_image[BIT_HEADSET_REMOVE] = latched_headset_flags[1];
        headset_image[BIT_HEADSET_HOOK] = latched_headset_flags[0];

        threshold_voice_image = STATUS_RESET;
        threshold_voice_image[BIT_GPA_UPPER] = latched_threshold_voice_flags[3];
        threshold_voice_image[BIT_GPA_LOWER] = latched_threshold_voice_flags[2];
        threshold_voice_image[BIT_VOICE_POWER_UP] = latched_threshold_voice_flags[1];
        threshold_voice_image[BIT_VOICE_POWER_DOWN] = latched_threshold_voice_flags[0];

        live_clock_image = STATUS_RESET;
        live_clock_image[BIT_CLOCK_ERROR] = live_clock_flags[1];
        live_clock_image[BIT_PLL_LOCK] = live_clock_flags[0];

        channel_summary_image = STATUS_RESET;
        channel_summary_image[BIT_INPUT_CH1] = channel_fault_summary_bits[3];
        channel_summary_image[BIT_INPUT_CH2] = channel_fault_summary_bits[2];
        channel_summary_image[BIT_OUTPUT_CH1] = channel_fault_summary_bits[1];
        channel_summary_image[BIT_OUTPUT_CH2] = channel_fault_summary_bits[0];

        output_one_image = STATUS_RESET;
        output_one_image[BIT_POS_SHORT] = output_one_fault_bits[3];
        output_one_image[BIT_NEG_SHORT] = output_one_fault_bits[2];
        output_one_image[BIT_POS_VGND] = output_one_fault_bits[1];
        output_one_image[BIT_NEG_VGND] = output_one_fault_bits[0];
    end

    always_comb begin
        if (reg_addr == ADDR_LATCHED_HEADSET) begin
            next_rdata = headset_image;
        end else if (reg_addr == ADDR_LATCHED_THRESHOLD_VOICE) begin
            next_rdata = threshold_voice_image;
        end else if (reg_addr == ADDR_LIVE_CLOCK) begin
            next_rdata = live_clock_image;
        end else if (reg_addr == ADDR_LIVE_CHANNEL_SUMMARY) begin
            next_rdata = channel_summary_image;
        end else if (reg_addr == ADDR_LIVE_OUTPUT_ONE) begin
            next_rdata = output_one_image;
        end else begin
            next_rdata = READ_UNMAPPED;
        end
    end

    // Read data is captured with the flags as they were before the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= STATUS_RESET;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // Writes are acknowledged and discarded
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_wr_ack <= 1'b0;
        end else begin
            reg_wr_ack <= reg_wr;
        end
    end

endmodule : interrupt_fault_status_readback

`default_nettype wire

// ==== tb/fault_status_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module fault_status_props
    import fault_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid,
    input wire logic reg_wr_ack,
    input wire logic headset_insert_event,
    input wire logic clock_error,
    input wire logic pll_lock
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    write_ack_a: assert property (reg_wr && !reg_rd |=> reg_wr_ack && $stable(reg_rdata))
        else $error("write disturbed read data or missed ack");
    reset_zero_a: assert property ($rose(rst_n) |-> reg_rdata == 8'h00 && !reg_rd_valid)
        else $error("outputs not cleared by reset");
    clock_live_a: assert property (reg_rd && reg_addr == 8'h3C && $past(rst_n)
        |=> reg_rdata[7] == $past(clock_error, 2)) else $error("clock error bit wrong");
    pll_live_a: assert property (reg_rd && reg_addr == 8'h3C && $past(rst_n)
        |=> reg_rdata[6] == $past(pll_lock, 2)) else $error("pll lock bit wrong");
    insert_latch_a: assert property (headset_insert_event ##1 reg_rd && reg_addr == 8'h3A
        |=> reg_rdata[3]) else $error("insert flag not latched");
    latch_clear_a: assert property (reg_rd && reg_addr == 8'h3A && !headset_insert_event
        ##1 reg_rd && reg_addr == 8'h3A |=> !reg_rdata[3]) else $error("flag not cleared by read");
    latch_reserved_a: assert property (reg_rd && reg_addr == 8'h3A |=> reg_rdata[7:4] == 4'h0)
        else $error("reserved headset bits set");
    out_reserved_a: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata[3:0] == 4'h0)
        else $error("reserved output bits set");
endmodule : fault_status_props
bind interrupt_fault_status_readback fault_status_props u_fault_status_props (
    .clk, .rst_n, .reg_addr, .reg_rd, .reg_wr, .reg_rdata, .reg_rd_valid, .reg_wr_ack,
    .headset_insert_event, .clock_error, .pll_lock
);
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module tb_top
    import fault_status_pkg::*;
;
    logic clk = 0;
    logic rst_n = 0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_rd = 0;
    logic reg_wr = 0;
    logic [6:0] ev = 7'h00;
    logic [9:0] lv = 10'h000;
    logic [7:0] reg_rdata;
    logic reg_rd_valid;
    logic reg_wr_ack;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [7:0] l1, l2, v0, v1, v2, m_data;
    logic m_rv, m_wa;
    logic [7:0] amap [6] = '{ADDR_LATCHED_HEADSET, ADDR_LATCHED_THRESHOLD_VOICE, ADDR_LIVE_CLOCK,
        ADDR_LIVE_CHANNEL_SUMMARY, ADDR_LIVE_OUTPUT_ONE, 8'h3E};
    interrupt_fault_status_readback u_interrupt_fault_status_readback (
        .clk, .rst_n, .reg_addr, .reg_rd, .reg_wr, .reg_rdata, .reg_rd_valid, .reg_wr_ack,
        .headset_insert_event(ev[6]), .headset_remove_event(ev[5]), .headset_hook_event(ev[4]),
        .analog_input_upper_event(ev[3]), .analog_input_lower_event(ev[2]),
        .voice_power_up_event(ev[1]), .voice_power_down_event(ev[0]),
        .clock_error(lv[9]), .pll_lock(lv[8]), .input_ch1_fault(lv[7]), .input_ch2_fault(lv[6]),
        .output_ch1_fault(lv[5]), .output_ch2_fault(lv[4]), .output_one_positive_pin_short(lv[3]),
        .output_one_negative_pin_short(lv[2]), .positive_driver_vgnd_fault(lv[1]),
        .negative_driver_vgnd_fault(lv[0])
    );
    initial begin
        forever #10 clk = ~clk;
    end
    // Reference model: read image taken before this edge's clear and set
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {l1, l2, v0, v1, v2, m_data, m_rv, m_wa} = '0;
        end else begin
            m_rv = reg_rd;
            m_wa = reg_wr;
            if (reg_rd) begin
                m_data = reg_addr == 8'h3A ? l1 : reg_addr == 8'h3B ? l2 : reg_addr == 8'h3C ? v0 :
                    reg_addr == 8'h3D ? v1 : reg_addr == 8'h40 ? v2 : 8'h00;
            end
            if (reg_rd && reg_addr == 8'h3A) l1 = 8'h00;
            if (reg_rd && reg_addr == 8'h3B) l2 = 8'h00;
            l1 = l1 | {4'h0, ev[6:4], 1'b0};
            l2 = l2 | {ev[3:0], 4'h0};
            v0 = {lv[9:8], 6'h00};
            v1 = {lv[7:4], 4'h0};
            v2 = {lv[3:0], 4'h0};
        end
    end
    always @(negedge clk) begin
        `CHK("rd_valid", m_rv, reg_rd_valid)
        `CHK("wr_ack", m_wa, reg_wr_ack)
        `CHK("rdata", m_data, reg_rdata)
    end
    task automatic cycles(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            // Events are the AND of three random words, so each bit is high about one cycle in eight
            ev = 7'($urandom & $urandom & $urandom);
            if ($urandom % 16 == 0) lv = 10'($urandom);
            reg_rd = 1'($urandom);
            reg_wr = ($urandom % 4) == 0;
            reg_addr = amap[$urandom % 6];
        end
    endtask : cycles
    task automatic complete_run();
        $display("tests %0d errors %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(53711));
        repeat (16) @(posedge clk);
        #1 rst_n = 1;
        cycles(3000);
        #5 rst_n = 0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1;
        cycles(3000);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
